// ---- slpd_board_model.sv ----
// board side of the strap latch: strap resistors and the power-good/power-down driver
// assumes the bench sets the wanted straps and a go level just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module slpd_board_model #(
    parameter int SETTLE = 4
) (
    input  wire logic i_clk,
    input  wire logic i_sel_lo,
    input  wire logic i_sel_hi,
    input  wire logic i_sel_mid,
    input  wire logic i_go,
    output logic      o_pg_n,
    output logic      o_lo,
    output logic      o_hi,
    output logic      o_mid
);
    logic [2:0] held_reg  = 3'h0;
    logic [2:0] quiet_reg = 3'h0;
    logic       pin_reg   = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // straps settle first
    // power-good is raised once the still count from before this edge reaches SETTLE; a strap change on that same edge does not hold it back
    always @(posedge i_clk)
    begin
        if ({i_sel_mid, i_sel_hi, i_sel_lo} !== held_reg)
            quiet_reg <= 3'h0;
        else if (quiet_reg != 3'h7)
            quiet_reg <= quiet_reg + 3'h1;
        held_reg <= {i_sel_mid, i_sel_hi, i_sel_lo};
        pin_reg  <= i_go && (pin_reg || (int'(quiet_reg) >= SETTLE));
    end

    assign o_pg_n = pin_reg;
    assign {o_mid, o_hi, o_lo} = held_reg;
endmodule : slpd_board_model
`default_nettype wire

// ---- slpd_defs.svh ----
// holds the register offsets, field positions and reset values of the strap latch block
// assumes inclusion by bare name from the bench and the top module
`ifndef SLPD_DEFS_SVH
`define SLPD_DEFS_SVH

`define SLPD_OFF_STATUS      8'h00
`define SLPD_OFF_OUT_CTRL    8'h04
`define SLPD_OFF_NV_ADDR     8'h08
`define SLPD_OFF_NV_DATA     8'h0c

`define SLPD_OUT_CTRL_RST    4'hf
`define SLPD_NV_ADDR_RST     7'h00
`define SLPD_NV_INIT         32'h00000000

`define SLPD_STAT_LATCHED    0
`define SLPD_STAT_PWRDOWN    1
`define SLPD_STAT_FREQ_LSB   4
`define SLPD_STAT_SPREAD_LSB 8

`endif

// ---- slpd_pkg.sv ----
// holds the types shared by the strap latch block
// assumes slpd_defs.svh sits in the same folder
`default_nettype none
package slpd_pkg;
    typedef enum logic [1:0] {FREQ_100, FREQ_125, FREQ_200} slpd_freq_t;
    typedef enum logic [1:0] {SPREAD_OFF, SPREAD_DOWN_050, SPREAD_CENTRE_025,
                              SPREAD_DOWN_075} slpd_spread_t;
    typedef enum logic {ST_WAIT_GOOD, ST_LIVE} slpd_state_t;
endpackage : slpd_pkg
`default_nettype wire

// ---- slpd_strap_if.sv ----
// carries the latched strap choice and power-down state between the block's modules
// assumes one producer and one consumer on the same clock
`timescale 1ns/100ps
`default_nettype none
interface slpd_strap_if;
    import slpd_pkg::*;
    logic         latched;
    logic         pwrdown;
    slpd_freq_t   freq;
    slpd_spread_t spread;
    modport src (output latched, output pwrdown, output freq, output spread);
    modport snk (input latched, input pwrdown, input freq, input spread);
endinterface : slpd_strap_if
`default_nettype wire

// ---- slpd_strap_latch.sv ----
// holds the power-good synchroniser, the one-shot strap capture and the strap decode
// assumes the select straps are steady before power-good rises
`timescale 1ns/100ps
`default_nettype none
module slpd_strap_latch (
    input  wire logic   i_clk,
    input  wire logic   i_rst,
    input  wire logic   i_pg_n,
    input  wire logic   i_sel_lo,
    input  wire logic   i_sel_hi,
    input  wire logic   i_sel_hi_mid,
    slpd_strap_if.src   strap
);
    import slpd_pkg::*;

    logic        meta_reg, meta_next;
    logic        sync_reg, sync_next;
    slpd_state_t state_reg, state_next;
    logic        lo_reg, lo_next;
    logic        hi_reg, hi_next;
    logic        mid_reg, mid_next;
    logic        pd_reg, pd_next;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        meta_next  = i_pg_n;
        sync_next  = meta_reg;
        state_next = state_reg;
        lo_next    = lo_reg;
        hi_next    = hi_reg;
        mid_next   = mid_reg;
        case (state_reg)
            ST_WAIT_GOOD:
            begin
                if (sync_reg)
                begin
                    state_next = ST_LIVE;
                    lo_next    = i_sel_lo;
                    hi_next    = i_sel_hi;
                    mid_next   = i_sel_hi_mid;
                end
            end
            ST_LIVE: state_next = ST_LIVE;
            default: state_next = ST_WAIT_GOOD;
        endcase
        // pin now a live low power-down
        pd_next = (state_next == ST_LIVE) && !sync_reg;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_reg  <= 1'b0;
            sync_reg  <= 1'b0;
            state_reg <= ST_WAIT_GOOD;
            lo_reg    <= 1'b0;
            hi_reg    <= 1'b0;
            mid_reg   <= 1'b0;
            pd_reg    <= 1'b0;
        end
        else
        begin
            meta_reg  <= meta_next;
            sync_reg  <= sync_next;
            state_reg <= state_next;
            lo_reg    <= lo_next;
            hi_reg    <= hi_next;
            mid_reg   <= mid_next;
            pd_reg    <= pd_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        // mid level wins over high, spread off
        if (mid_reg)
        begin
            strap.freq   = lo_reg ? FREQ_200 : FREQ_125;
            strap.spread = SPREAD_OFF;
        end
        else
        begin
            // binary strap table at 100 MHz
            strap.freq = FREQ_100;
            case ({hi_reg, lo_reg})
                2'b00:   strap.spread = SPREAD_OFF;
                2'b01:   strap.spread = SPREAD_DOWN_050;
                2'b10:   strap.spread = SPREAD_CENTRE_025;
                2'b11:   strap.spread = SPREAD_DOWN_075;
                default: strap.spread = SPREAD_OFF;
            endcase
        end
    end

    assign strap.latched = (state_reg == ST_LIVE);
    assign strap.pwrdown = pd_reg;

    ////////////////////////////////////////////////////////////////////////////////
    capture_value_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_reg == ST_WAIT_GOOD && sync_reg) |=> (state_reg == ST_LIVE)
            && lo_reg == $past(i_sel_lo) && hi_reg == $past(i_sel_hi)
            && mid_reg == $past(i_sel_hi_mid))
        else $error("strap not captured on power-good");

    sync_delay_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(strap.latched) |-> $past(i_pg_n, 3) && !$past(sync_reg, 2))
        else $error("capture not two flops behind the pin");

    strap_frozen_a: assert property (@(posedge i_clk) disable iff (i_rst)
        strap.latched |=> strap.latched && $stable(lo_reg) && $stable(hi_reg)
            && $stable(mid_reg))
        else $error("latched strap changed");
endmodule : slpd_strap_latch
`default_nettype wire

// ---- slpd_tb.sv ----
// self-checking bench of the strap latch and power-down control
// assumes slpd_top with default parameters and the board model beside it
`timescale 1ns/100ps
`default_nettype none
`include "slpd_defs.svh"
module tb;
    import slpd_pkg::*;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         go = 1'b0, s_lo = 1'b0, s_hi = 1'b0, s_mid = 1'b0;
    logic [3:0]   oe_pin = 4'hf;
    logic [7:0]   addr = 8'h00;
    logic [31:0]  wdata = 32'h0;
    logic         wr = 1'b0, rd = 1'b0;
    wire          pg_n, lo, hi, mid;
    logic [31:0]  rdata, rv;
    logic [3:0]   out_en;
    slpd_freq_t   freq;
    slpd_spread_t spread;
    logic         latched, pdown;
    int           error_cnt = 0;
    int           check_count = 0;
    // {freq, spread} for straps {mid, hi, lo} = 000..011, 100, 101
    localparam logic [3:0] EXP [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8};

    always #2 clk = ~clk;

    slpd_board_model i_board (.i_clk(clk), .i_sel_lo(s_lo), .i_sel_hi(s_hi),
        .i_sel_mid(s_mid), .i_go(go), .o_pg_n(pg_n), .o_lo(lo), .o_hi(hi), .o_mid(mid));

    slpd_top i_dut (.I_CLK(clk), .I_RST(rst), .I_PWRGOOD_PWRDOWN_N(pg_n),
        .I_FREQ_SPREAD_SELECT_LO(lo), .I_FREQ_SPREAD_SELECT_HI(hi),
        .I_FREQ_SPREAD_SELECT_HI_MID(mid), .I_OUT_ENABLE_PIN(oe_pin), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_DIFF_CLOCK_OUT_EN(out_en),
        .O_FREQ_SEL(freq), .O_SPREAD_SEL(spread), .O_STRAP_LATCHED(latched),
        .O_POWER_DOWN(pdown));

    ////////////////////////////////////////////////////////////////////////////////
    task chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr

    // read data stand only in the cycle after the strobe edge
    task bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : bus_rd

    // write then read of one address with no idle cycle between the strobes
    task bus_wr_rd(input logic [7:0] a, input logic [31:0] dw, output logic [31:0] dr);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= dw;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 dr = rdata;
    endtask : bus_wr_rd

    task do_reset;
        rst <= 1'b1;
        go <= 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset

    task capture(input logic [2:0] st);
        int n;
        {s_mid, s_hi, s_lo} <= st;
        go <= 1'b1;
        for (n = 0; n < 30 && latched !== 1'b1; n++) @(posedge clk);
        @(posedge clk);
        #1 chk_val("latched", 32'h1, 32'(latched));
    endtask : capture

    ////////////////////////////////////////////////////////////////////////////////
    task test_reset_regs;
        repeat (3) @(posedge clk);
        #1 chk_val("pdown before capture", 32'h0, 32'(pdown));
        chk_val("out_en before capture", 32'h0, 32'(out_en));
        bus_wr(`SLPD_OFF_STATUS, 32'hffffffff);
        bus_rd(`SLPD_OFF_STATUS, rv);
        chk_val("status", 32'h0, rv);
        bus_rd(`SLPD_OFF_OUT_CTRL, rv);
        chk_val("out ctrl", 32'hf, rv);
        bus_rd(`SLPD_OFF_NV_ADDR, rv);
        chk_val("nv addr", 32'h0, rv);
        bus_rd(8'h10, rv);
        chk_val("unmapped", 32'h0, rv);
    endtask : test_reset_regs

    task test_decode;
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            do_reset();
            capture(3'((i > 3) ? i : i));
            chk_val("freq", 32'(EXP[i][3:2]), 32'(freq));
            chk_val("spread", 32'(EXP[i][1:0]), 32'(spread));
            chk_val("out_en", 32'hf, 32'(out_en));
            bus_rd(`SLPD_OFF_STATUS, rv);
            chk_val("status", {22'h0, EXP[i][1:0], 2'h0, EXP[i][3:2], 4'h1}, rv);
        end
    endtask : test_decode

    task test_pdown;
        @(posedge clk);
        {s_mid, s_hi, s_lo} <= 3'h7;
        go <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk_val("pdown sync delay", 32'h0, 32'(pdown));
        @(posedge clk);
        #1 chk_val("pdown", 32'h1, 32'(pdown));
        chk_val("out_en in pdown", 32'h0, 32'(out_en));
        @(posedge clk);
        go <= 1'b1;
        repeat (7) @(posedge clk);
        #1 chk_val("pdown released", 32'h0, 32'(pdown));
        chk_val("freq kept", 32'(EXP[5][3:2]), 32'(freq));
        chk_val("spread kept", 32'(EXP[5][1:0]), 32'(spread));
        chk_val("still latched", 32'h1, 32'(latched));
    endtask : test_pdown

    task test_enables;
        @(posedge clk);
        oe_pin <= 4'ha;
        repeat (3) @(posedge clk);
        #1 chk_val("out_en pins", 32'ha, 32'(out_en));
        bus_wr(`SLPD_OFF_OUT_CTRL, 32'h6);
        repeat (3) @(posedge clk);
        #1 chk_val("out_en pins and sw", 32'h2, 32'(out_en));
        bus_rd(`SLPD_OFF_OUT_CTRL, rv);
        chk_val("out ctrl", 32'h6, rv);
    endtask : test_enables

    task test_store;
        bus_wr(`SLPD_OFF_NV_ADDR, 32'h7f);
        bus_wr(`SLPD_OFF_NV_DATA, 32'ha5c3_0ff1);
        bus_wr(`SLPD_OFF_NV_ADDR, 32'h0);
        bus_wr_rd(`SLPD_OFF_NV_DATA, 32'h1234_5678, rv);
        chk_val("store word 0", 32'h1234_5678, rv);
        bus_wr(`SLPD_OFF_NV_ADDR, 32'h7f);
        bus_rd(`SLPD_OFF_NV_DATA, rv);
        chk_val("store word 127", 32'ha5c3_0ff1, rv);
    endtask : test_store

    task give_verdict;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset();
        test_reset_regs();
        test_decode();
        test_pdown();
        test_enables();
        test_store();
        give_verdict();
    end

    // the whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
endmodule : tb
`default_nettype wire

// ---- slpd_top.sv ----
// top of the strap latch and power-down control; holds registers and output gating
// assumes straps synchronous to I_CLK and a master that never waits
`timescale 1ns/100ps
`default_nettype none
`include "slpd_defs.svh"
module slpd_top #(
    parameter int NV_WORDS = 128,
    parameter int N_OUT    = 4
) (
    input  wire logic               I_CLK,
    input  wire logic               I_RST,
    input  wire logic               I_PWRGOOD_PWRDOWN_N,
    input  wire logic               I_FREQ_SPREAD_SELECT_LO,
    input  wire logic               I_FREQ_SPREAD_SELECT_HI,
    input  wire logic               I_FREQ_SPREAD_SELECT_HI_MID,
    input  wire logic [N_OUT-1:0]   I_OUT_ENABLE_PIN,
    input  wire logic [7:0]         I_ADDR,
    input  wire logic [31:0]        I_WDATA,
    input  wire logic               I_WR,
    input  wire logic               I_RD,
    output logic [31:0]             O_RDATA,
    output logic [N_OUT-1:0]        O_DIFF_CLOCK_OUT_EN,
    output slpd_pkg::slpd_freq_t    O_FREQ_SEL,
    output slpd_pkg::slpd_spread_t  O_SPREAD_SEL,
    output logic                    O_STRAP_LATCHED,
    output logic                    O_POWER_DOWN
);
    import slpd_pkg::*;

    localparam int NV_AW = $clog2(NV_WORDS);

    slpd_strap_if strap ();

    slpd_strap_latch u_latch (
        .i_clk        (I_CLK),
        .i_rst        (I_RST),
        .i_pg_n       (I_PWRGOOD_PWRDOWN_N),
        .i_sel_lo     (I_FREQ_SPREAD_SELECT_LO),
        .i_sel_hi     (I_FREQ_SPREAD_SELECT_HI),
        .i_sel_hi_mid (I_FREQ_SPREAD_SELECT_HI_MID),
        .strap        (strap.src)
    );

    logic [N_OUT-1:0] sw_en_reg, sw_en_next;
    logic [NV_AW-1:0] nv_addr_reg, nv_addr_next;
    logic [31:0]      nv_reg [NV_WORDS];
    logic [31:0]      nv_next [NV_WORDS];
    logic [31:0]      rdata_reg, rdata_next;
    logic [N_OUT-1:0] en_reg, en_next;
    slpd_freq_t       freq_reg, freq_next;
    slpd_spread_t     spread_reg, spread_next;
    logic             latched_reg, latched_next;
    logic             pd_reg, pd_next;
    logic [31:0]      status;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        status = 32'h00000000;
        status[`SLPD_STAT_LATCHED] = latched_reg;
        status[`SLPD_STAT_PWRDOWN] = pd_reg;
        status[`SLPD_STAT_FREQ_LSB +: 2]   = freq_reg;
        status[`SLPD_STAT_SPREAD_LSB +: 2] = spread_reg;

        sw_en_next   = sw_en_reg;
        nv_addr_next = nv_addr_reg;
        nv_next      = nv_reg;
        rdata_next   = 32'h00000000;
        if (I_WR)
        begin
            case (I_ADDR)
                `SLPD_OFF_OUT_CTRL: sw_en_next   = I_WDATA[N_OUT-1:0];
                `SLPD_OFF_NV_ADDR:  nv_addr_next = I_WDATA[NV_AW-1:0];
                `SLPD_OFF_NV_DATA:  nv_next[nv_addr_reg] = I_WDATA;
                default:            sw_en_next   = sw_en_reg;
            endcase
        end
        // unmapped reads answer zero so software can probe safely
        if (I_RD)
        begin
            case (I_ADDR)
                `SLPD_OFF_STATUS:   rdata_next = status;
                `SLPD_OFF_OUT_CTRL: rdata_next[N_OUT-1:0] = sw_en_reg;
                `SLPD_OFF_NV_ADDR:  rdata_next[NV_AW-1:0] = nv_addr_reg;
                `SLPD_OFF_NV_DATA:  rdata_next = nv_reg[nv_addr_reg];
                default:            rdata_next = 32'h00000000;
            endcase
        end

        freq_next    = strap.freq;
        spread_next  = strap.spread;
        latched_next = strap.latched;
        pd_next      = strap.pwrdown;
        // per-output pin enable masked by the software enable, gated by run state
        en_next = (strap.latched && !strap.pwrdown) ?
                  (I_OUT_ENABLE_PIN & sw_en_reg) : {N_OUT{1'b0}};
    end

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            sw_en_reg   <= {N_OUT{1'b1}};
            nv_addr_reg <= `SLPD_NV_ADDR_RST;
            // store comes back with its build-time contents
            for (int i = 0; i < NV_WORDS; i++)
            begin
                nv_reg[i] <= `SLPD_NV_INIT;
            end
            rdata_reg   <= 32'h00000000;
            en_reg      <= {N_OUT{1'b0}};
            freq_reg    <= FREQ_100;
            spread_reg  <= SPREAD_OFF;
            latched_reg <= 1'b0;
            pd_reg      <= 1'b0;
        end
        else
        begin
            sw_en_reg   <= sw_en_next;
            nv_addr_reg <= nv_addr_next;
            nv_reg      <= nv_next;
            rdata_reg   <= rdata_next;
            en_reg      <= en_next;
            freq_reg    <= freq_next;
            spread_reg  <= spread_next;
            latched_reg <= latched_next;
            pd_reg      <= pd_next;
        end
    end

    assign O_RDATA             = rdata_reg;
    assign O_DIFF_CLOCK_OUT_EN = en_reg;
    assign O_FREQ_SEL          = freq_reg;
    assign O_SPREAD_SEL        = spread_reg;
    assign O_STRAP_LATCHED     = latched_reg;
    assign O_POWER_DOWN        = pd_reg;

    ////////////////////////////////////////////////////////////////////////////////
    pwrdown_live_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (strap.latched && !$past(I_PWRGOOD_PWRDOWN_N, 2) && !$past(I_PWRGOOD_PWRDOWN_N, 3))
            |=> O_POWER_DOWN ##1 (O_DIFF_CLOCK_OUT_EN == {N_OUT{1'b0}}))
        else $error("low pin after capture did not power down");

    binary_decode_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        $rose(strap.latched) && !$past(I_FREQ_SPREAD_SELECT_HI_MID)
            |=> O_FREQ_SEL == FREQ_100 && O_SPREAD_SEL ==
                ({$past(I_FREQ_SPREAD_SELECT_HI, 2), $past(I_FREQ_SPREAD_SELECT_LO, 2)}
                 == 2'b00 ? SPREAD_OFF :
                 {$past(I_FREQ_SPREAD_SELECT_HI, 2), $past(I_FREQ_SPREAD_SELECT_LO, 2)}
                 == 2'b01 ? SPREAD_DOWN_050 :
                 {$past(I_FREQ_SPREAD_SELECT_HI, 2), $past(I_FREQ_SPREAD_SELECT_LO, 2)}
                 == 2'b10 ? SPREAD_CENTRE_025 : SPREAD_DOWN_075))
        else $error("binary strap decoded wrongly");

    mid_decode_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        $rose(strap.latched) && $past(I_FREQ_SPREAD_SELECT_HI_MID)
            |=> O_SPREAD_SEL == SPREAD_OFF && O_FREQ_SEL ==
                ($past(I_FREQ_SPREAD_SELECT_LO, 2) ? FREQ_200 : FREQ_125))
        else $error("mid-level strap decoded wrongly");

    nv_readback_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_WR && I_ADDR == `SLPD_OFF_NV_DATA) ##1 (I_RD && I_ADDR == `SLPD_OFF_NV_DATA)
            |=> O_RDATA == $past(I_WDATA, 2))
        else $error("store did not return written word");

    pin_gate_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (O_DIFF_CLOCK_OUT_EN & ~$past(I_OUT_ENABLE_PIN)) == {N_OUT{1'b0}})
        else $error("output enabled while its pin was low");

    capture_once_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_STRAP_LATCHED |=> O_STRAP_LATCHED && $stable(O_FREQ_SEL) && $stable(O_SPREAD_SEL))
        else $error("strap choice changed after capture");

    latch_needs_good_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        $rose(O_STRAP_LATCHED) |-> $past(I_PWRGOOD_PWRDOWN_N, 4))
        else $error("capture without power-good high");

    rdata_idle_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        !$past(I_RD) |-> O_RDATA == 32'h00000000)
        else $error("read data not zero outside the read slot");

    status_latch_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        ($past(I_RD) && $past(I_ADDR) == `SLPD_OFF_STATUS)
            |-> O_RDATA[`SLPD_STAT_LATCHED] == $past(O_STRAP_LATCHED))
        else $error("status read lost the capture flag");

    pd_needs_latch_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_POWER_DOWN |-> O_STRAP_LATCHED)
        else $error("power-down before the strap was captured");

    pd_release_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        $past(I_PWRGOOD_PWRDOWN_N, 3) |=> !O_POWER_DOWN)
        else $error("power-down held with the pin high");

    pd_gates_out_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_POWER_DOWN |-> O_DIFF_CLOCK_OUT_EN == {N_OUT{1'b0}})
        else $error("output enabled during power-down");

    off_until_latch_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        !O_STRAP_LATCHED |-> O_DIFF_CLOCK_OUT_EN == {N_OUT{1'b0}})
        else $error("output enabled before capture");

    default_strap_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        !O_STRAP_LATCHED |-> O_FREQ_SEL == FREQ_100 && O_SPREAD_SEL == SPREAD_OFF)
        else $error("selects left the default before capture");
endmodule : slpd_top
`default_nettype wire
